// ### src/sbrt_pkg.sv
// shared constants and types of the serial baud reload timer
package sbrt_pkg;

	// ==========================================
	// bus geometry
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;
	localparam int NCHAN = 2;

	// ==========================================
	// register offsets, one word each
	localparam logic [2:0] OFS_WORD [NCHAN] = '{3'h0, 3'h1};
	localparam logic [2:0] OFS_CTRL [NCHAN] = '{3'h2, 3'h3};
	localparam logic [2:0] OFS_IRQ_STAT = 3'h4;
	localparam logic [2:0] OFS_IRQ_MASK = 3'h5;
	localparam logic [2:0] OFS_SYNC_SEL = 3'h6;

	// ==========================================
	// reset values
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [7:0] CTRL_RST = 8'h02;
	localparam logic [1:0] STAT_RST = 2'h0;
	localparam logic [1:0] MASK_RST = 2'h0;
	localparam logic [1:0] SYNC_RST = 2'h0;

	// ==========================================
	// control field positions
	localparam int BIT_MODE = 0;
	localparam int BIT_FIXED = 1;
	localparam int BIT_FLAG = 2;
	localparam int BIT_IEN = 3;
	localparam int BIT_RUN = 4;
	localparam int SEL_LSB = 5;

	// ==========================================
	// counts
	localparam logic [7:0] COUNT_MAX = 8'hff;
	localparam logic [3:0] BAUD_LAST_ASYNC = 4'hf;
	localparam logic [3:0] BAUD_LAST_SYNC = 4'h3;
	localparam int NTAPS = 6;
	localparam int TB_EXP [NTAPS] = '{1, 2, 3, 4, 6, 8};

	// ==========================================
	// control register layout
	typedef struct packed {
		logic [2:0] clk_sel;
		logic run;
		logic irq_en;
		logic flag;
		logic fixed_one;
		logic mode;
	} sbrt_ctrl_s;

endpackage

// ### src/sbrt_prescale.sv
// count clock enables for the eight clock select codes
`timescale 1ns/1ps
module sbrt_prescale (
	// clock and resets
	input wire logic clock,
	input wire logic rst,
	input wire logic soft_rst,
	// time base tick
	input wire logic time_base_clock,
	// enables, indexed by select code
	output logic [7:0] sel_tick
);

	// ==========================================
	// dividers
	logic half_q;
	logic [7:0] tb_cnt_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			half_q <= 1'b0;
		end else if (soft_rst) begin
			half_q <= 1'b0;
		end else begin
			half_q <= ~half_q;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tb_cnt_q <= 8'h00;
		end else if (soft_rst) begin
			tb_cnt_q <= 8'h00;
		end else if (time_base_clock) begin
			tb_cnt_q <= tb_cnt_q + 8'h01;
		end
	end

	// ==========================================
	// selection
	assign sel_tick[0] = 1'b1;
	assign sel_tick[1] = half_q;
	for (genvar i = 0; i < sbrt_pkg::NTAPS; i++) begin : g_tap
		// one tick every 2^exp time base ticks
		assign sel_tick[i + 2] = time_base_clock & (&tb_cnt_q[sbrt_pkg::TB_EXP[i] - 1:0]);
	end

endmodule

// ### src/sbrt_chan.sv
// one channel: counter, reload register and baud divider
`timescale 1ns/1ps
module sbrt_chan (
	// clock and resets
	input wire logic clock,
	input wire logic rst,
	input wire logic soft_rst,
	// control
	input wire logic count_tick,
	input wire logic baud_mode,
	input wire logic sync_mode,
	input wire logic wr_word,
	input wire logic [15:0] wdata,
	// state
	output logic [15:0] word,
	output logic overflow,
	output logic baud_tick_q
);

	// ==========================================
	// counter and reload
	logic [7:0] count_q;
	logic [7:0] reload_q;
	logic [3:0] div_q;
	logic [3:0] div_last;

	assign overflow = count_tick & (count_q == sbrt_pkg::COUNT_MAX);
	assign word = {reload_q, count_q};

	// a write wins over a same-cycle overflow reload
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count_q <= sbrt_pkg::WORD_RST[7:0];
		end else if (soft_rst) begin
			count_q <= sbrt_pkg::WORD_RST[7:0];
		end else if (wr_word) begin
			count_q <= wdata[7:0];
		end else if (overflow) begin
			count_q <= reload_q;
		end else if (count_tick) begin
			count_q <= count_q + 8'h01;
		end
	end

	// reload only reaches the counter at overflow
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			reload_q <= sbrt_pkg::WORD_RST[15:8];
		end else if (soft_rst) begin
			reload_q <= sbrt_pkg::WORD_RST[15:8];
		end else if (wr_word) begin
			reload_q <= wdata[15:8];
		end
	end

	// ==========================================
	// baud divider
	assign div_last = sync_mode ? sbrt_pkg::BAUD_LAST_SYNC : sbrt_pkg::BAUD_LAST_ASYNC;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			div_q <= 4'h0;
			baud_tick_q <= 1'b0;
		end else if (soft_rst || !baud_mode) begin
			div_q <= 4'h0;
			baud_tick_q <= 1'b0;
		end else if (overflow && div_q == div_last) begin
			div_q <= 4'h0;
			baud_tick_q <= 1'b1;
		end else begin
			if (overflow) begin
				div_q <= div_q + 4'h1;
			end
			baud_tick_q <= 1'b0;
		end
	end

endmodule

// ### src/sbrt_timer.sv
// serial baud reload timer, two channels behind a plain register port
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module sbrt_timer (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// further reset sources
	input wire logic break_instruction,
	input wire logic watchdog_overflow,
	input wire logic opcode_trap,
	// time base tick
	input wire logic time_base_clock,
	// register port
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata_q,
	// requests
	output logic [1:0] ovf_request_q,
	output logic vector_request_q,
	output logic irq_q,
	// serial side
	output logic [1:0] baud_tick
);

	// ==========================================
	// declarations
	localparam int N = sbrt_pkg::NCHAN;

	logic soft_rst;
	logic [7:0] sel_tick;
	sbrt_pkg::sbrt_ctrl_s ctrl_q [N];
	logic [15:0] word [N];
	logic [N-1:0] ovf;
	logic [N-1:0] wr_ctrl;
	logic [N-1:0] wr_word;
	logic [N-1:0] gated_ovf;
	logic [1:0] stat_q;
	logic [1:0] mask_q;
	logic [1:0] sync_q;
	logic [15:0] rd_mux;
	logic rd_stat;

	// ==========================================
	// reset sources
	assign soft_rst = break_instruction | watchdog_overflow | opcode_trap;

	// ==========================================
	// clock select
	sbrt_prescale u_prescale (
		.clock(clock),
		.rst(rst),
		.soft_rst(soft_rst),
		.time_base_clock(time_base_clock),
		.sel_tick(sel_tick)
	);

	// ==========================================
	// channels
	for (genvar i = 0; i < N; i++) begin : g_chan
		logic count_tick;

		assign wr_word[i] = reg_wr & (reg_addr == sbrt_pkg::OFS_WORD[i]);
		assign wr_ctrl[i] = reg_wr & (reg_addr == sbrt_pkg::OFS_CTRL[i]);
		assign count_tick = ctrl_q[i].run & sel_tick[ctrl_q[i].clk_sel];
		assign gated_ovf[i] = ovf[i] & ctrl_q[i].irq_en;

		sbrt_chan u_chan (
			.clock(clock),
			.rst(rst),
			.soft_rst(soft_rst),
			.count_tick(count_tick),
			.baud_mode(ctrl_q[i].mode),
			.sync_mode(sync_q[i]),
			.wr_word(wr_word[i]),
			.wdata(reg_wdata),
			.word(word[i]),
			.overflow(ovf[i]),
			.baud_tick_q(baud_tick[i])
		);

		// control register; the flag set wins over a same-cycle write
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				ctrl_q[i] <= sbrt_pkg::CTRL_RST;
			end else if (soft_rst) begin
				ctrl_q[i] <= sbrt_pkg::CTRL_RST;
			end else begin
				if (wr_ctrl[i]) begin
					ctrl_q[i].clk_sel <= reg_wdata[sbrt_pkg::SEL_LSB +: 3];
					ctrl_q[i].run <= reg_wdata[sbrt_pkg::BIT_RUN];
					ctrl_q[i].irq_en <= reg_wdata[sbrt_pkg::BIT_IEN];
					ctrl_q[i].mode <= reg_wdata[sbrt_pkg::BIT_MODE];
				end
				if (ovf[i]) begin
					ctrl_q[i].flag <= 1'b1;
				end else if (wr_ctrl[i]) begin
					ctrl_q[i].flag <= reg_wdata[sbrt_pkg::BIT_FLAG];
				end
				ctrl_q[i].fixed_one <= 1'b1;
			end
		end

		// request pulse lands on the reload edge
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				ovf_request_q[i] <= 1'b0;
			end else begin
				ovf_request_q[i] <= gated_ovf[i] & ~soft_rst;
			end
		end
	end

	// ==========================================
	// shared vector
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			vector_request_q <= 1'b0;
		end else begin
			vector_request_q <= (|gated_ovf) & ~soft_rst;
		end
	end

	// ==========================================
	// interrupt status, mask and sync select
	assign rd_stat = reg_rd & (reg_addr == sbrt_pkg::OFS_IRQ_STAT);

	// a read clears, but an overflow in that cycle survives
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			stat_q <= sbrt_pkg::STAT_RST;
		end else if (soft_rst) begin
			stat_q <= sbrt_pkg::STAT_RST;
		end else if (rd_stat) begin
			stat_q <= ovf;
		end else begin
			stat_q <= stat_q | ovf;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mask_q <= sbrt_pkg::MASK_RST;
		end else if (soft_rst) begin
			mask_q <= sbrt_pkg::MASK_RST;
		end else if (reg_wr && reg_addr == sbrt_pkg::OFS_IRQ_MASK) begin
			mask_q <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync_q <= sbrt_pkg::SYNC_RST;
		end else if (soft_rst) begin
			sync_q <= sbrt_pkg::SYNC_RST;
		end else if (reg_wr && reg_addr == sbrt_pkg::OFS_SYNC_SEL) begin
			sync_q <= reg_wdata[1:0];
		end
	end

	// level follows status one cycle later
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat_q & mask_q);
		end
	end

	// ==========================================
	// read path
	always_comb begin
		rd_mux = 16'h0000;
		for (int k = 0; k < N; k++) begin
			if (reg_addr == sbrt_pkg::OFS_WORD[k]) begin
				rd_mux = word[k];
			end
			if (reg_addr == sbrt_pkg::OFS_CTRL[k]) begin
				rd_mux = {8'h00, ctrl_q[k]};
			end
		end
		if (reg_addr == sbrt_pkg::OFS_IRQ_STAT) begin
			rd_mux = {14'h0000, stat_q};
		end
		if (reg_addr == sbrt_pkg::OFS_IRQ_MASK) begin
			rd_mux = {14'h0000, mask_q};
		end
		if (reg_addr == sbrt_pkg::OFS_SYNC_SEL) begin
			rd_mux = {14'h0000, sync_q};
		end
	end

	// data stand only in the cycle after the strobe
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			reg_rdata_q <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata_q <= rd_mux;
		end else begin
			reg_rdata_q <= 16'h0000;
		end
	end

	// ==========================================
	// assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	for (genvar i = 0; i < N; i++) begin : g_chk
		a_reload_on_ovf: assert property (
			ovf[i] && !soft_rst && !wr_word[i]
			|=> word[i][7:0] == $past(word[i][15:8])
		) else $error("counter not reloaded at overflow");

		a_request_same: assert property (
			ovf[i] && ctrl_q[i].irq_en && !soft_rst
			|=> ovf_request_q[i] && ctrl_q[i].flag
		) else $error("overflow request or flag missing");

		a_request_gated: assert property (
			!ctrl_q[i].irq_en |=> !ovf_request_q[i]
		) else $error("request raised while disabled");

		a_flag_sticky: assert property (
			ctrl_q[i].flag && !wr_ctrl[i] && !soft_rst |=> ctrl_q[i].flag
		) else $error("overflow flag lost without write");

		a_flag_on_ovf: assert property (
			ovf[i] && !soft_rst |=> ctrl_q[i].flag
		) else $error("overflow did not set flag");

		a_flag_clear: assert property (
			wr_ctrl[i] && !reg_wdata[sbrt_pkg::BIT_FLAG] && !ovf[i] && !soft_rst
			|=> !ctrl_q[i].flag
		) else $error("flag not cleared by write");

		a_ctrl_write: assert property (
			wr_ctrl[i] && !soft_rst
			|=> ctrl_q[i].clk_sel == $past(reg_wdata[7:5])
			&& ctrl_q[i].run == $past(reg_wdata[4])
			&& ctrl_q[i].irq_en == $past(reg_wdata[3])
			&& ctrl_q[i].mode == $past(reg_wdata[0])
		) else $error("control write not taken");

		a_reload_write: assert property (
			wr_word[i] && !soft_rst
			|=> word[i] == $past(reg_wdata)
		) else $error("word write not taken as written");

		a_stop_hold: assert property (
			!ctrl_q[i].run && !wr_word[i] && !soft_rst
			|=> $stable(word[i][7:0])
		) else $error("stopped counter moved");

		a_count_step: assert property (
			ctrl_q[i].run && ctrl_q[i].clk_sel == 3'h0
			&& !ovf[i] && !wr_word[i] && !soft_rst
			|=> word[i][7:0] == $past(word[i][7:0]) + 8'h01
		) else $error("counter did not step on master clock");

		a_baud_cause: assert property (
			baud_tick[i] |-> $past(ovf[i]) && $past(ctrl_q[i].mode)
		) else $error("baud tick without overflow");

		a_baud_idle: assert property (
			!ctrl_q[i].mode |=> !baud_tick[i]
		) else $error("baud tick in timer mode");

		a_status_set: assert property (
			ovf[i] && !soft_rst |=> stat_q[i]
		) else $error("overflow did not set status");

		c_overflow: cover property (ovf[i] ##1 ovf_request_q[i]);
		c_baud: cover property (baud_tick[i]);
	end

	a_soft_reset: assert property (
		soft_rst |=> word[0] == 16'h0000 && ctrl_q[0] == 8'h02 && word[1] == 16'h0000
	) else $error("reset source did not clear timer");

	a_fixed_read: assert property (
		reg_rd && reg_addr == sbrt_pkg::OFS_CTRL[0] |=> reg_rdata_q[1]
	) else $error("unimplemented bit did not read one");

	a_vector_share: assert property (
		ovf_request_q != 2'h0 |-> vector_request_q
	) else $error("shared vector missed a request");

	a_status_clear: assert property (
		rd_stat && !soft_rst |=> stat_q == $past(ovf)
	) else $error("status read did not clear");

	a_irq_level: assert property (
		irq_q == $past(|(stat_q & mask_q))
	) else $error("irq level does not follow status");

	a_read_idle: assert property (
		!reg_rd |=> reg_rdata_q == 16'h0000
	) else $error("read data outside read cycle");

	a_read_word: assert property (
		reg_rd && reg_addr == sbrt_pkg::OFS_WORD[0]
		|=> reg_rdata_q == $past(word[0])
	) else $error("word read does not match");

	// half rate may never give two ticks in a row
	a_half_rate: assert property (
		sel_tick[1] |=> !sel_tick[1]
	) else $error("half rate tick repeated");

	a_base_gate: assert property (
		!time_base_clock |-> sel_tick[7:2] == 6'h00
	) else $error("time base tick without time base");

	a_sync_write: assert property (
		reg_wr && reg_addr == sbrt_pkg::OFS_SYNC_SEL && !soft_rst
		|=> sync_q == $past(reg_wdata[1:0])
	) else $error("sync select write not taken");

	a_mask_write: assert property (
		reg_wr && reg_addr == sbrt_pkg::OFS_IRQ_MASK && !soft_rst
		|=> mask_q == $past(reg_wdata[1:0])
	) else $error("mask write not taken");

	c_irq: cover property (irq_q ##1 rd_stat);
	c_sync_baud: cover property (sync_q[0] && baud_tick[0]);

endmodule

// ### test/sbrt_serial_model.sv
// partner model: serial bit-timing side, measures baud tick spacing
`timescale 1ns/1ps
module sbrt_serial_model (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// baud ticks from the timer
	input wire logic [1:0] baud_tick,
	// spacing in cycles and tick count, per channel
	output logic [1:0][15:0] gap_q,
	output logic [1:0][15:0] seen_q
);
	// ==========================================
	// tick spacing
	logic [1:0][15:0] run_q;

	// only the spacing matters here, so no bit framing is modelled
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			run_q <= '0;
			gap_q <= '0;
			seen_q <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (baud_tick[c]) begin
					gap_q[c] <= run_q[c];
					run_q[c] <= 16'h0001;
					seen_q[c] <= seen_q[c] + 16'h0001;
				end else begin
					run_q[c] <= run_q[c] + 16'h0001;
				end
			end
		end
	end
endmodule

// ### test/sbrt_timer_tb.sv
// testbench of the serial baud reload timer
`timescale 1ns/1ps
module sbrt_timer_tb;
	// ==========================================
	// signals
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [2:0] src_q = 3'h0;
	logic time_base_clock = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata_q;
	logic [1:0] ovf_request_q;
	logic vector_request_q;
	logic irq_q;
	logic [1:0] baud_tick;
	logic [1:0][15:0] gap_q;
	logic [1:0][15:0] seen_q;
	int fail_count = 0;
	int checks_done = 0;
	localparam int DIV [8] = '{1, 2, 2, 4, 8, 16, 64, 256};
	localparam int TB_PER = 2;
	logic tb_phase_q = 1'b0;

	always #20 clock = ~clock;

	// time base pulses every other cycle, so codes 2 to 7 differ from the master clock
	always @(posedge clock) begin
		tb_phase_q <= ~tb_phase_q;
		time_base_clock <= tb_phase_q;
	end

	sbrt_timer i_dut (.clock(clock), .rst(rst), .break_instruction(src_q[0]),
		.watchdog_overflow(src_q[1]), .opcode_trap(src_q[2]),
		.time_base_clock(time_base_clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.ovf_request_q(ovf_request_q), .vector_request_q(vector_request_q),
		.irq_q(irq_q), .baud_tick(baud_tick));

	sbrt_serial_model i_far (.clock(clock), .rst(rst), .baud_tick(baud_tick),
		.gap_q(gap_q), .seen_q(seen_q));

	// ==========================================
	// shared tasks
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int k);
		@(posedge clock);
		#1;
		if (k > 8000) begin
			fail_count++;
			end_of_test();
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata_q;
	endtask

	// ==========================================
	// scenarios
	task automatic t_regs();
		logic [15:0] d;
		logic [15:0] exp [8] = '{16'h0000, 16'h0000, 16'h0002, 16'h0002,
			16'h0000, 16'h0000, 16'h0000, 16'h0000};
		for (int a = 0; a < 8; a++) begin
			rd(3'(a), d);
			chk("reset value", exp[a], d);
		end
		wr(sbrt_pkg::OFS_CTRL[0], 16'h0000);
		rd(sbrt_pkg::OFS_CTRL[0], d);
		chk("fixed bit", 16'h0002, d);
		wr(sbrt_pkg::OFS_WORD[0], 16'habcd);
		rd(sbrt_pkg::OFS_WORD[0], d);
		chk("word layout", 16'habcd, d);
	endtask

	task automatic wait_ovf(output int n);
		n = 0;
		do begin
			n++;
			tick(n);
		end while (ovf_request_q[0] !== 1'b1);
		chk("shared vector", 16'h0001, {15'h0, vector_request_q});
	endtask

	task automatic t_reload();
		int n;
		wr(sbrt_pkg::OFS_WORD[0], 16'hf0fe);
		wr(sbrt_pkg::OFS_CTRL[0], 16'h0018);
		wait_ovf(n);
		wait_ovf(n);
		chk("reload period", 16'h0010, 16'(n));
		wr(sbrt_pkg::OFS_CTRL[0], 16'h0000);
	endtask

	task automatic t_irq();
		logic [15:0] d;
		int n = 0;
		wr(sbrt_pkg::OFS_WORD[0], 16'h00fe);
		wr(sbrt_pkg::OFS_CTRL[0], 16'h0010);
		repeat (300) begin
			tick(0);
			if (ovf_request_q[0] === 1'b1) n++;
		end
		chk("gated request", 16'h0000, 16'(n));
		rd(sbrt_pkg::OFS_CTRL[0], d);
		chk("sticky flag", 16'h0016, d);
		chk("masked irq", 16'h0000, {15'h0, irq_q});
		wr(sbrt_pkg::OFS_CTRL[0], 16'h0000);
		rd(sbrt_pkg::OFS_CTRL[0], d);
		chk("flag cleared", 16'h0002, d);
		wr(sbrt_pkg::OFS_IRQ_MASK, 16'h0001);
		repeat (2) tick(0);
		chk("irq level", 16'h0001, {15'h0, irq_q});
		rd(sbrt_pkg::OFS_IRQ_STAT, d);
		chk("irq status", 16'h0001, d);
		repeat (2) tick(0);
		chk("irq after read", 16'h0000, {15'h0, irq_q});
	endtask

	task automatic t_sources();
		logic [15:0] d;
		for (int s = 0; s < 3; s++) begin
			wr(sbrt_pkg::OFS_WORD[1], 16'h1234);
			wr(sbrt_pkg::OFS_CTRL[1], 16'h0019);
			@(posedge clock);
			src_q <= 3'(1 << s);
			@(posedge clock);
			src_q <= 3'h0;
			rd(sbrt_pkg::OFS_WORD[1], d);
			chk("word after reset source", 16'h0000, d);
			rd(sbrt_pkg::OFS_CTRL[1], d);
			chk("ctrl after reset source", 16'h0002, d);
		end
	endtask

	task automatic t_chan3();
		logic [15:0] d;
		int n = 0;
		wr(sbrt_pkg::OFS_IRQ_MASK, 16'h0002);
		wr(sbrt_pkg::OFS_WORD[1], 16'h00fd);
		wr(sbrt_pkg::OFS_CTRL[1], 16'h0018);
		do begin
			n++;
			tick(n);
		end while (ovf_request_q[1] !== 1'b1);
		chk("chan3 overflow delay", 16'h0003, 16'(n));
		chk("chan3 vector", 16'h0001, {15'h0, vector_request_q});
		wr(sbrt_pkg::OFS_CTRL[1], 16'h0000);
		tick(0);
		chk("chan3 irq", 16'h0001, {15'h0, irq_q});
		rd(sbrt_pkg::OFS_IRQ_STAT, d);
		chk("chan3 status", 16'h0002, d);
	endtask

	// reload ff gives one count clock per overflow, so spacing is the count clock period (DIV, x TB_PER for codes 2 to 7) x 16 or 4
	task automatic baud(input int ch, input logic [2:0] code, input logic sync, input int p);
		int base;
		int k = 0;
		wr(sbrt_pkg::OFS_CTRL[ch], 16'h0000);
		wr(sbrt_pkg::OFS_SYNC_SEL, {14'h0, sync, sync});
		wr(sbrt_pkg::OFS_WORD[ch], 16'hffff);
		wr(sbrt_pkg::OFS_CTRL[ch], {8'h00, code, 5'h11});
		base = int'(seen_q[ch]);
		while (int'(seen_q[ch]) - base < 3) begin
			k++;
			tick(k);
		end
		chk("baud spacing", 16'(p), gap_q[ch]);
	endtask

	// ==========================================
	// main sequence
	initial begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		t_regs();
		t_reload();
		t_irq();
		t_sources();
		t_chan3();
		for (int c = 0; c < 8; c++) begin
			baud(0, 3'(c), 1'b1, 4 * DIV[c] * ((c < 2) ? 1 : TB_PER));
		end
		baud(0, 3'h0, 1'b0, 16);
		baud(1, 3'h1, 1'b0, 32);
		end_of_test();
	end
endmodule
